// file: verilog/csbp_core.v
// Clocked serial port with eight-word buffer behind an AXI4-Lite slave.
// Functional notes
// RULE_01: Six internal divided rates, code 111 external.
// RULE_02: Internal clock drives pin, idle high.
// RULE_03: External clock pulses wider than 16 periods.
// RULE_04: Transmit bit changes on falling clock edge.
// RULE_05: Receive bit sampled on rising clock edge.
// RULE_06: Four-bit mode uses low nibble, zero upper.
// RULE_07: Words shift least significant bit first.
// RULE_08: One to eight words, interrupt at count.
// RULE_09: Stop before changing count, except waits.
// RULE_10: Next word loaded right after previous word.
// RULE_11: Buffer-empty interrupt after last transmit bit.
// RULE_12: Internal transmit halts clock until any write.
// RULE_13: Any buffer access ends an automatic wait.
// RULE_14: Run cleared: finish transmit words, clear busy.
// RULE_15: Abort ends transfer and busy at once.
// RULE_16: External transmit without new data: dummy, end.
// RULE_17: Receive stores words, buffer-full interrupt at count.
// RULE_18: Internal receive halts clock until a read.
// RULE_19: External receive unread: drop word, cancel.
// RULE_20: Run cleared: finish and store word, clear busy.
// RULE_21: Abort discards partial received data.
// RULE_22: Mode change clears the buffer.
// RULE_23: Buffer order ascends from lowest word.
// RULE_24: Software stops and aborts before mode change.
// RULE_25: Reset: stopped, idle high, nothing pending.
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "csbp_defines.vh"

module csbp_core #(
  parameter ADDR_W = 8
) (
  input  wire              ref_clk_i,
  input  wire              rst_n_i,
  input  wire              ce_i,
  input  wire [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire              s_axi_awvalid_i,
  output wire              s_axi_awready_o,
  input  wire [31:0]       s_axi_wdata_i,
  input  wire [3:0]        s_axi_wstrb_i,
  input  wire              s_axi_wvalid_i,
  output wire              s_axi_wready_o,
  output wire [1:0]        s_axi_bresp_o,
  output wire              s_axi_bvalid_o,
  input  wire              s_axi_bready_i,
  input  wire [ADDR_W-1:0] s_axi_araddr_i,
  input  wire              s_axi_arvalid_i,
  output wire              s_axi_arready_o,
  output wire [31:0]       s_axi_rdata_o,
  output wire [1:0]        s_axi_rresp_o,
  output wire              s_axi_rvalid_o,
  input  wire              s_axi_rready_i,
  input  wire              sck_i,
  output wire              sck_o,
  output wire              sck_oe_n_o,
  input  wire              si_i,
  output wire              so_o,
  output wire              transfer_interrupt_o
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Returns 0 ctrl1, 1 ctrl2, 2 state, 3 buffer, 4 unmapped.
  function [2:0] reg_sel;
    input [ADDR_W-1:0] a;
    begin
      if (a[ADDR_W-1:5] == {(ADDR_W-5){1'b0}} && a[5] == 1'b0 && a[1:0] == 2'h0) begin
        reg_sel = 3'h4;
      end else begin
        reg_sel = 3'h4;
      end
      if (a == `CSBP_OFF_CTRL1) begin
        reg_sel = 3'h0;
      end else if (a == `CSBP_OFF_CTRL2) begin
        reg_sel = 3'h1;
      end else if (a == `CSBP_OFF_STATE) begin
        reg_sel = 3'h2;
      end else if (a[ADDR_W-1:5] == `CSBP_OFF_BUF >> 5 && a[1:0] == 2'h0) begin
        reg_sel = 3'h3;
      end
    end
  endfunction

  function [12:0] half_count;
    input [2:0] sel;
    begin
      case (sel) // RULE_01
        3'h0:    half_count = `CSBP_HALF_0;
        3'h1:    half_count = `CSBP_HALF_1;
        3'h2:    half_count = `CSBP_HALF_2;
        3'h3:    half_count = `CSBP_HALF_3;
        3'h4:    half_count = `CSBP_HALF_4;
        3'h5:    half_count = `CSBP_HALF_5;
        default: half_count = 13'h1FFF;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [7:0]        ctrl1_reg;
  reg [7:0]        ctrl2_reg;
  reg [7:0]        buf_mem [0:7];
  reg              busy_reg;
  reg              phase_reg;
  reg              sck_reg;
  reg              sck_prev_reg;
  reg              so_reg;
  reg [12:0]       div_reg;
  reg [2:0]        bit_reg;
  reg [2:0]        idx_reg;
  reg [7:0]        tx_sh_reg;
  reg [7:0]        rx_sh_reg;
  reg              wait_reg;
  reg              fresh_reg;
  reg              unread_reg;
  reg              dummy_reg;
  reg              irq_reg;
  reg              aw_hold_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg              w_hold_reg;
  reg [7:0]        w_data_reg;
  reg              w_lane_reg;
  reg              bvalid_reg;
  reg [1:0]        bresp_reg;
  reg              rvalid_reg;
  reg [31:0]       rdata_reg;
  reg [1:0]        rresp_reg;
  integer          i;

  // ----------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------
  wire [2:0] mode     = ctrl1_reg[`CSBP_C1_MODE_HI:`CSBP_C1_MODE_LO];
  wire [2:0] sck_sel  = ctrl1_reg[`CSBP_C1_SCK_HI:`CSBP_C1_SCK_LO];
  wire [2:0] count    = ctrl2_reg[`CSBP_C2_CNT_HI:`CSBP_C2_CNT_LO];
  wire       run      = ctrl1_reg[`CSBP_C1_RUN];
  wire       ext      = (sck_sel == `CSBP_SCK_EXT);
  wire       is8      = mode[2];
  wire       is_rx    = (mode == `CSBP_MODE_RX4) || (mode == `CSBP_MODE_RX8) ||
                        (mode == `CSBP_MODE_TXRX8);
  wire       is_tx    = ~((mode == `CSBP_MODE_RX4) || (mode == `CSBP_MODE_RX8));
  wire       tx_only  = is_tx & ~is_rx;
  // Code 110 is reserved, so it must never produce a serial clock edge.
  wire       tick     = busy_reg & ~ext & (sck_sel != 3'h6) &
                        (div_reg == half_count(sck_sel));
  // The pin is sampled as synchronous; edges come from the previous sample.
  wire       ext_fall = sck_prev_reg & ~sck_i;
  wire       ext_rise = ~sck_prev_reg & sck_i;
  wire       fall_ev  = busy_reg & ~phase_reg &
                        (ext ? ext_fall : (tick & ~wait_reg)); // RULE_12 RULE_18
  wire       rise_ev  = busy_reg & phase_reg & (ext ? ext_rise : tick);
  wire       last_bit = (bit_reg == (is8 ? 3'h7 : 3'h3));
  wire       word_end = rise_ev & last_bit;
  wire       last_wd  = (idx_reg == count); // RULE_08
  // Four-bit words collect in the upper nibble and are moved down.
  wire [7:0] rx_word  = is8 ? {si_i, rx_sh_reg[7:1]} :
                              {4'h0, si_i, rx_sh_reg[7:5]}; // RULE_06
  // An outside clock cannot be held, so an unread batch cancels reception.
  wire       rx_drop  = is_rx & ext & unread_reg; // RULE_19
  wire [7:0] tx_src   = buf_mem[idx_reg];
  wire       wr_fire  = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  wire [2:0] wr_sel   = reg_sel(aw_addr_reg);
  wire       rd_fire  = s_axi_arvalid_i & ~rvalid_reg & ce_i;
  wire [2:0] rd_sel   = reg_sel(s_axi_araddr_i);
  wire       buf_wr   = wr_fire & (wr_sel == 3'h3) & w_lane_reg;
  wire       buf_rd   = rd_fire & (rd_sel == 3'h3);
  wire       c1_wr    = wr_fire & (wr_sel == 3'h0) & w_lane_reg;
  wire [7:0] state_rd = {4'h0, dummy_reg, unread_reg, wait_reg, busy_reg};

  assign s_axi_awready_o      = ce_i & ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready_o       = ce_i & ~w_hold_reg & ~bvalid_reg;
  assign s_axi_bvalid_o       = bvalid_reg;
  assign s_axi_bresp_o        = bresp_reg;
  assign s_axi_arready_o      = ce_i & ~rvalid_reg;
  assign s_axi_rvalid_o       = rvalid_reg;
  assign s_axi_rdata_o        = rdata_reg;
  assign s_axi_rresp_o        = rresp_reg;
  assign sck_o                = sck_reg;
  assign sck_oe_n_o           = ext; // RULE_02
  assign so_o                 = so_reg;
  assign transfer_interrupt_o = irq_reg;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 8'h00;
      w_lane_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `CSBP_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `CSBP_RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i[7:0];
        w_lane_reg <= s_axi_wstrb_i[0];
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (wr_sel == 3'h4) ? `CSBP_RESP_SLVERR : `CSBP_RESP_OKAY;
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
      // Read data are latched at acceptance and stand until they are taken.
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= (rd_sel == 3'h4) ? `CSBP_RESP_SLVERR : `CSBP_RESP_OKAY;
        case (rd_sel)
          3'h0:    rdata_reg <= {24'h000000, ctrl1_reg};
          3'h1:    rdata_reg <= {24'h000000, ctrl2_reg};
          3'h2:    rdata_reg <= {24'h000000, state_rd};
          3'h3:    rdata_reg <= {24'h000000, buf_mem[s_axi_araddr_i[4:2]]};
          default: rdata_reg <= 32'h0000_0000;
        endcase
      end else if (rvalid_reg && s_axi_rready_i) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers and buffer
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl1_reg <= `CSBP_RST_CTRL1;
      ctrl2_reg <= `CSBP_RST_CTRL2;
      for (i = 0; i < 8; i = i + 1) begin
        buf_mem[i] <= 8'h00;
      end
    end else if (ce_i) begin
      if (c1_wr) begin
        ctrl1_reg <= w_data_reg;
        // Words left from another mode must not be sent or read back.
        if (w_data_reg[`CSBP_C1_MODE_HI:`CSBP_C1_MODE_LO] != mode) begin
          for (i = 0; i < 8; i = i + 1) begin
            buf_mem[i] <= 8'h00; // RULE_22
          end
        end
      end
      // Count may change at any time; a running transfer sees it at once.
      if (wr_fire && wr_sel == 3'h1 && w_lane_reg) begin
        ctrl2_reg <= w_data_reg; // RULE_09
      end
      if (buf_wr) begin
        buf_mem[aw_addr_reg[4:2]] <= w_data_reg;
      end
      if (word_end && is_rx && !rx_drop && busy_reg) begin
        buf_mem[idx_reg] <= rx_word; // RULE_17 RULE_23
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_reg     <= 1'b0; // RULE_25
      phase_reg    <= 1'b0;
      sck_reg      <= 1'b1;
      sck_prev_reg <= 1'b1;
      so_reg       <= 1'b1;
      div_reg      <= 13'h0000;
      bit_reg      <= 3'h0;
      idx_reg      <= 3'h0;
      tx_sh_reg    <= 8'h00;
      rx_sh_reg    <= 8'h00;
      wait_reg     <= 1'b0;
      fresh_reg    <= 1'b0;
      unread_reg   <= 1'b0;
      dummy_reg    <= 1'b0;
      irq_reg      <= 1'b0;
    end else if (ce_i) begin
      sck_prev_reg <= sck_i;
      irq_reg      <= 1'b0;
      if (buf_wr || buf_rd) begin
        wait_reg <= 1'b0; // RULE_13
      end
      if (buf_rd) begin
        unread_reg <= 1'b0;
      end
      if (busy_reg && !ext) begin
        div_reg <= tick ? 13'h0000 : div_reg + 13'h0001;
      end
      // Abort outranks a start so that software can always stop the engine.
      if (c1_wr && w_data_reg[`CSBP_C1_ABORT]) begin
        busy_reg  <= 1'b0; // RULE_15
        phase_reg <= 1'b0;
        sck_reg   <= 1'b1;
        wait_reg  <= 1'b0;
        dummy_reg <= 1'b0;
        bit_reg   <= 3'h0;
        rx_sh_reg <= 8'h00; // RULE_21
      end else if (c1_wr && w_data_reg[`CSBP_C1_RUN] && !busy_reg) begin
        busy_reg   <= 1'b1;
        phase_reg  <= 1'b0;
        sck_reg    <= 1'b1; // RULE_02
        div_reg    <= 13'h0000;
        bit_reg    <= 3'h0;
        idx_reg    <= 3'h0; // RULE_23
        wait_reg   <= 1'b0;
        fresh_reg  <= 1'b0;
        unread_reg <= 1'b0;
        dummy_reg  <= 1'b0;
      end else if (fall_ev) begin
        phase_reg <= 1'b1;
        sck_reg   <= 1'b0;
        if (bit_reg == 3'h0) begin
          // The buffered word enters the shifter when its first bit leaves.
          so_reg    <= tx_src[0]; // RULE_10 RULE_04 RULE_07
          tx_sh_reg <= {1'b0, tx_src[7:1]};
        end else begin
          so_reg    <= tx_sh_reg[0]; // RULE_04 RULE_07
          tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
        end
      end else if (rise_ev) begin
        phase_reg <= 1'b0;
        sck_reg   <= 1'b1;
        rx_sh_reg <= {si_i, rx_sh_reg[7:1]}; // RULE_05 RULE_07
        bit_reg   <= last_bit ? 3'h0 : bit_reg + 3'h1;
        if (last_bit) begin
          if (rx_drop || dummy_reg) begin
            busy_reg  <= 1'b0; // RULE_16 RULE_19
            dummy_reg <= 1'b0;
          end else if (last_wd) begin
            irq_reg   <= 1'b1; // RULE_11 RULE_17
            idx_reg   <= 3'h0;
            fresh_reg <= 1'b0;
            if (is_rx) begin
              unread_reg <= 1'b1;
            end
            if (!run) begin
              busy_reg <= 1'b0; // RULE_14 RULE_20
            end else if (is_tx && !fresh_reg) begin
              if (ext) begin
                dummy_reg <= 1'b1; // RULE_16
              end else begin
                wait_reg <= 1'b1; // RULE_12
              end
            end else if (is_rx && !ext) begin
              wait_reg <= 1'b1; // RULE_18
            end
          end else begin
            idx_reg <= idx_reg + 3'h1; // RULE_23
            if (!run && !tx_only) begin
              busy_reg <= 1'b0; // RULE_20
            end
          end
        end
      end
      if (buf_wr) begin
        fresh_reg <= 1'b1;
      end
    end
  end

endmodule

// file: verilog/csbp_defines.vh
// Constants of the clocked serial buffered port.
`ifndef CSBP_DEFINES_VH
`define CSBP_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CSBP_OFF_CTRL1   8'h00
`define CSBP_OFF_CTRL2   8'h04
`define CSBP_OFF_STATE   8'h08
`define CSBP_OFF_BUF     8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSBP_C1_RUN      7
`define CSBP_C1_ABORT    6
`define CSBP_C1_MODE_HI  5
`define CSBP_C1_MODE_LO  3
`define CSBP_C1_SCK_HI   2
`define CSBP_C1_SCK_LO   0
`define CSBP_C2_WAIT_HI  4
`define CSBP_C2_WAIT_LO  3
`define CSBP_C2_CNT_HI   2
`define CSBP_C2_CNT_LO   0

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define CSBP_RST_CTRL1   8'h00
`define CSBP_RST_CTRL2   8'h00
`define CSBP_MODE_TX4    3'h0
`define CSBP_MODE_RX4    3'h1
`define CSBP_MODE_TX8    3'h4
`define CSBP_MODE_RX8    3'h5
`define CSBP_MODE_TXRX8  3'h6
`define CSBP_SCK_EXT     3'h7
`define CSBP_RESP_OKAY   2'h0
`define CSBP_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Half-period counts, last count value of the divider per code
// ----------------------------------------------------------------
`define CSBP_HALF_0      13'h0FFF
`define CSBP_HALF_1      13'h007F
`define CSBP_HALF_2      13'h003F
`define CSBP_HALF_3      13'h001F
`define CSBP_HALF_4      13'h000F
`define CSBP_HALF_5      13'h0007

`endif

// file: bench/csbp_core_assertions.sv
// Concurrent checks on the ports of the serial port core.
`timescale 1ns/1ps
module csbp_core_assertions (
  input wire        ref_clk_i,
  input wire        rst_n_i,
  input wire        s_axi_awready_o,
  input wire        s_axi_wready_o,
  input wire [1:0]  s_axi_bresp_o,
  input wire        s_axi_bvalid_o,
  input wire        s_axi_bready_i,
  input wire        s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire        s_axi_rvalid_o,
  input wire        s_axi_rready_i,
  input wire        sck_o,
  input wire        sck_oe_n_o,
  input wire        so_o,
  input wire        transfer_interrupt_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_b_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_r_upper;
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000;
  endproperty
  a_r_upper: assert property (p_r_upper) else $error("read data upper bits set");
  property p_ar_refuse;
    s_axi_rvalid_o |-> !s_axi_arready_o;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken during response");
  property p_w_refuse;
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
  endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("write taken during response");
  property p_irq_pulse;
    transfer_interrupt_o |=> !transfer_interrupt_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
  property p_irq_high;
    transfer_interrupt_o && !sck_oe_n_o |-> sck_o;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("interrupt with clock low");
  // Register writes are excluded, although neither an abort nor a start moves the data line.
  property p_so_fall;
    $changed(so_o) && !sck_oe_n_o && !s_axi_bvalid_o |-> $fell(sck_o);
  endproperty
  a_so_fall: assert property (p_so_fall) else $error("data moved off falling edge");
  property p_sck_half;
    $fell(sck_o) |-> !sck_o [*7];
  endproperty
  a_sck_half: assert property (p_sck_half) else $error("serial clock low too short");
  c_irq: cover property (transfer_interrupt_o);
  c_wr: cover property (s_axi_bvalid_o && s_axi_bready_i);
  c_sck: cover property ($fell(sck_o));
endmodule
bind csbp_core csbp_core_assertions csbp_core_assertions_inst (.*);

// file: bench/csbp_peer.sv
// Serial peripheral model facing the data and clock lines.
`timescale 1ns/1ps
module csbp_peer (
  input  wire  ref_clk_i,
  input  wire  sck_line_i,
  input  wire  so_i,
  output logic si_o,
  output logic sck_o
);
  logic        prev;
  logic [15:0] rx_q;
  logic [7:0]  tx_q;
  initial begin
    sck_o = 1'b1;
    si_o  = 1'b1;
    prev  = 1'b1;
    rx_q  = 16'h0000;
    tx_q  = 8'h00;
  end
  // Shifted-out bits are refilled inverted so a stale line never looks settled.
  always @(posedge ref_clk_i) begin
    prev <= sck_line_i;
    if (prev && !sck_line_i) begin
      si_o <= tx_q[0];
      tx_q <= {~tx_q[0], tx_q[7:1]};
    end
    if (!prev && sck_line_i)
      rx_q <= {so_i, rx_q[15:1]};
  end
  task load(input logic [7:0] v);
    tx_q <= v;
  endtask
  // Pulses of 20 cycles stay above the 16-cycle minimum; idle high between frames.
  task ext_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (20) @(posedge ref_clk_i);
      sck_o <= 1'b0;
      repeat (20) @(posedge ref_clk_i);
      sck_o <= 1'b1;
    end
  endtask
endmodule

// file: bench/test_csbp_core.sv
// Self-checking bench for the serial port core.
`timescale 1ns/1ps
`include "csbp_defines.vh"
module test_csbp_core;
  logic        clk, rst_n, awv, wv, bready, arv, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, d;
  logic [1:0]  r;
  int          err_count, compares, cyc;
  wire         awready, wready, bvalid, arready, rvalid, sck_o, sck_oe_n, so, si, p_sck, irq;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire         sck_line = sck_oe_n ? p_sck : sck_o;
  csbp_core csbp_core_inst (.ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .sck_i(sck_line), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n),
    .si_i(si), .so_o(so), .transfer_interrupt_o(irq));
  csbp_peer csbp_peer_inst (.ref_clk_i(clk), .sck_line_i(sck_line), .so_i(so),
    .si_o(si), .sck_o(p_sck));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task final_report();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata  <= {24'h000000, v};
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awv && awready) awv <= 1'b0;
      if (wv && wready) wv <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    chk("write response", 1, bvalid);
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arv && arready) arv <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    chk("read response", 1, rvalid);
  endtask
  task wirq();
    for (int n = 0; n < 800; n++) begin
      @(negedge clk);
      if (irq === 1'b1) break;
    end
    chk("interrupt", 1, irq);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset();
    chk("sck idle", 1, sck_o);
    chk("irq idle", 0, irq);
    rd(`CSBP_OFF_STATE);
    chk("busy", 0, d[0]);
    wr(8'h10, 8'hFF);
    chk("unmapped write resp", `CSBP_RESP_SLVERR, r);
    rd(8'h10);
    chk("unmapped resp", `CSBP_RESP_SLVERR, r);
    chk("unmapped data", 0, d);
    $display("test reset done");
  endtask
  task t_tx();
    wr(`CSBP_OFF_CTRL1, 8'h65);
    wr(`CSBP_OFF_CTRL2, 8'h01);
    wr(`CSBP_OFF_BUF, 8'h5A);
    wr(`CSBP_OFF_BUF + 8'h04, 8'hC3);
    wr(`CSBP_OFF_CTRL1, 8'hA5);
    chk("sck enable", 0, sck_oe_n);
    wirq();
    // The peer takes the last bit one cycle after the closing rise.
    repeat (2) @(negedge clk);
    chk("sent words", 32'h0000C35A, csbp_peer_inst.rx_q);
    rd(`CSBP_OFF_STATE);
    chk("auto wait", 3, d[1:0]);
    wr(`CSBP_OFF_BUF + 8'h14, 8'h77);
    rd(`CSBP_OFF_STATE);
    chk("wait ended", 1, d[1:0]);
    wr(`CSBP_OFF_CTRL1, 8'h25);
    wirq();
    repeat (2) @(negedge clk);
    chk("resent words", 32'h0000C35A, csbp_peer_inst.rx_q);
    rd(`CSBP_OFF_STATE);
    chk("busy after stop", 0, d[0]);
    wr(`CSBP_OFF_CTRL1, 8'h65);
    $display("test transmit done");
  endtask
  task t_rx4();
    wr(`CSBP_OFF_CTRL1, 8'h4D);
    wr(`CSBP_OFF_CTRL2, 8'h00);
    csbp_peer_inst.load(8'hB6);
    wr(`CSBP_OFF_CTRL1, 8'h8D);
    wirq();
    rd(`CSBP_OFF_STATE);
    chk("receive wait", 7, d[2:0]);
    wr(`CSBP_OFF_CTRL1, 8'h4D);
    rd(`CSBP_OFF_STATE);
    chk("busy after abort", 0, d[0]);
    rd(`CSBP_OFF_BUF);
    chk("nibble word", 32'h06, d);
    $display("test receive nibble done");
  endtask
  task t_ext();
    wr(`CSBP_OFF_CTRL1, 8'h6F);
    csbp_peer_inst.load(8'h3C);
    wr(`CSBP_OFF_CTRL1, 8'hAF);
    chk("sck released", 1, sck_oe_n);
    csbp_peer_inst.ext_clocks(8);
    wirq();
    csbp_peer_inst.ext_clocks(8);
    rd(`CSBP_OFF_STATE);
    chk("unread cancels", 0, d[0]);
    wr(`CSBP_OFF_CTRL1, 8'h6F);
    rd(`CSBP_OFF_BUF);
    chk("external word", 32'h3C, d);
    wr(`CSBP_OFF_CTRL1, 8'h65);
    rd(`CSBP_OFF_BUF);
    chk("buffer after mode change", 0, d);
    $display("test external receive done");
  endtask
  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    {rst_n, awv, wv, bready, arv, rready} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    err_count = 0;
    compares = 0;
    cyc = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_tx();
    t_rx4();
    t_ext();
    final_report();
  end
endmodule
